// ### core/cc_axil_slave.sv
/*
 AXI4-Lite slave front end: takes address and data in either order,
 issues one write or read strobe to the register bank.
 Assumes the bank decodes combinationally in the strobe cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module cc_axil_slave
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [cc_pkg::CC_ADDR_W-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [cc_pkg::CC_DATA_W-1:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [cc_pkg::CC_ADDR_W-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [cc_pkg::CC_DATA_W-1:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  cc_reg_if.slave bus
);
  import cc_pkg::*;
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [CC_ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [CC_DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  cc_rd_e rd_reg, rd_next;

  // -------------------------------------------------------------------
  // write and read channels
  // -------------------------------------------------------------------
  // no new address or data while a response waits: one write at a time
  assign awready_o = !aw_full_reg && !bvalid_reg;
  assign wready_o = !w_full_reg && !bvalid_reg;
  assign arready_o = (rd_reg == CC_RD_IDLE);
  assign bus.wr_req = aw_full_reg && w_full_reg && !bvalid_reg;
  assign bus.wr_addr = awaddr_reg;
  assign bus.wr_data = wdata_reg;
  assign bus.wr_strb = wstrb_reg;
  assign bus.rd_req = arvalid_i && arready_o;
  assign bus.rd_addr = araddr_i;

  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rd_next = rd_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (awvalid_i && awready_o) begin
      aw_full_next = 1'b1;
      awaddr_next = awaddr_i;
    end
    if (wvalid_i && wready_o) begin
      w_full_next = 1'b1;
      wdata_next = wdata_i;
      wstrb_next = wstrb_i;
    end
    if (bus.wr_req) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = bus.wr_ok ? CC_RESP_OKAY : CC_RESP_SLVERR;
    end else if (bvalid_reg && bready_i) begin
      bvalid_next = 1'b0;
    end
    unique case (rd_reg)
      CC_RD_IDLE: begin
        if (bus.rd_req) begin
          rd_next = CC_RD_RESP;
          rdata_next = bus.rd_data;
          rresp_next = bus.rd_ok ? CC_RESP_OKAY : CC_RESP_SLVERR;
        end
      end
      CC_RD_RESP: begin
        if (rready_i) begin
          rd_next = CC_RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= CC_RESP_OKAY;
      rd_reg <= CC_RD_IDLE;
      rdata_reg <= '0;
      rresp_reg <= CC_RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rd_reg <= rd_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign bvalid_o = bvalid_reg;
  assign bresp_o = bresp_reg;
  assign rvalid_o = (rd_reg == CC_RD_RESP);
  assign rdata_o = rdata_reg;
  assign rresp_o = rresp_reg;
endmodule
`default_nettype wire

// ### core/cc_core_control.sv
/*
 Core control register of the signal-processing engine, on AXI4-Lite.
 Assumes loop and priority events come from logic on the same clock.
*/
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cc_core_control
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [cc_pkg::CC_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [cc_pkg::CC_DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [cc_pkg::CC_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [cc_pkg::CC_DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [2:0] cpu_status_reg_i,
  input wire logic priority_raise_i,
  input wire logic priority_drop_i,
  input wire logic loop_start_i,
  input wire logic loop_iter_end_i,
  input wire logic loop_done_i,
  output logic unsigned_multiply_o,
  output logic integer_mode_o,
  output logic accum_a_saturate_o,
  output logic accum_b_saturate_o,
  output logic data_write_saturate_o,
  output logic saturation_point_select_o,
  output logic program_space_window_o,
  output logic rounding_mode_o,
  output logic [3:0] cpu_priority_level_o,
  output logic [cc_pkg::CC_DEPTH_W-1:0] loop_nesting_depth_o,
  output logic loop_exit_o
);
  import cc_pkg::*;

  cc_reg_if bus ();
  cc_loop_if #(.DEPTH_W(CC_DEPTH_W)) lp ();

  logic [15:0] ctl_reg, ctl_next;
  logic [15:0] view;
  logic wr_hit, rd_hit, wr_lo, wr_hi;
  logic [15:0] wd;

  // -------------------------------------------------------------------
  // bus front end and loop counter
  // -------------------------------------------------------------------
  cc_axil_slave u_slave (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .awaddr_i(s_axi_awaddr_i),
    .awvalid_i(s_axi_awvalid_i),
    .awready_o(s_axi_awready_o),
    .wdata_i(s_axi_wdata_i),
    .wstrb_i(s_axi_wstrb_i),
    .wvalid_i(s_axi_wvalid_i),
    .wready_o(s_axi_wready_o),
    .bresp_o(s_axi_bresp_o),
    .bvalid_o(s_axi_bvalid_o),
    .bready_i(s_axi_bready_i),
    .araddr_i(s_axi_araddr_i),
    .arvalid_i(s_axi_arvalid_i),
    .arready_o(s_axi_arready_o),
    .rdata_o(s_axi_rdata_o),
    .rresp_o(s_axi_rresp_o),
    .rvalid_o(s_axi_rvalid_o),
    .rready_i(s_axi_rready_i),
    .bus(bus.slave)
  );

  cc_loop_tracker #(.DEPTH_W(CC_DEPTH_W)) u_loop (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .lp(lp.track)
  );

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  // the low two address bits are ignored: word access only
  assign wr_hit = (bus.wr_addr[CC_ADDR_W-1:2] == CC_CORE_CONTROL_OFS[CC_ADDR_W-1:2]);
  assign rd_hit = (bus.rd_addr[CC_ADDR_W-1:2] == CC_CORE_CONTROL_OFS[CC_ADDR_W-1:2]);
  assign wr_lo = bus.wr_req && wr_hit && bus.wr_strb[0];
  assign wr_hi = bus.wr_req && wr_hit && bus.wr_strb[1];
  assign wd = bus.wr_data[15:0];
  assign bus.wr_ok = wr_hit;
  assign bus.rd_ok = rd_hit;

  // read view; unused and exit bits are never stored
  always_comb begin
    view = ctl_reg;
    view[15:13] = 3'h0;
    view[CC_EXIT_BIT] = 1'b0;
    view[CC_DEPTH_LSB +: CC_DEPTH_W] = lp.depth;
  end
  assign bus.rd_data = rd_hit ? {16'h0, view} : '0;

  // -------------------------------------------------------------------
  // register update
  // -------------------------------------------------------------------
  always_comb begin
    ctl_next = ctl_reg;
    if (wr_lo) begin
      ctl_next[7:0] = (wd[7:0] & CC_WMASK[7:0]) | (ctl_reg[7:0] & ~CC_WMASK[7:0]);
      // priority msb: a written zero clears, a written one is ignored
      ctl_next[CC_PRIO_BIT] = ctl_reg[CC_PRIO_BIT] & wd[CC_PRIO_BIT];
    end
    if (wr_hi) begin
      ctl_next[15:8] = (wd[15:8] & CC_WMASK[15:8]) | (ctl_reg[15:8] & ~CC_WMASK[15:8]);
    end
    if (priority_drop_i) begin
      ctl_next[CC_PRIO_BIT] = 1'b0;
    end
    // set wins over any clear in the same cycle
    if (priority_raise_i) begin
      ctl_next[CC_PRIO_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_reg <= CC_RESET;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  // -------------------------------------------------------------------
  // loop hookup
  // -------------------------------------------------------------------
  assign lp.start = loop_start_i;
  assign lp.iter_end = loop_iter_end_i;
  assign lp.done = loop_done_i;
  // a write of one fires once; zero does nothing
  assign lp.exit_req = wr_hi && wd[CC_EXIT_BIT];
  assign loop_exit_o = lp.exit_now;
  assign loop_nesting_depth_o = lp.depth;

  // -------------------------------------------------------------------
  // engine controls
  // -------------------------------------------------------------------
  assign unsigned_multiply_o = ctl_reg[CC_UMUL_BIT];
  assign accum_a_saturate_o = ctl_reg[CC_SAT_A_BIT];
  assign accum_b_saturate_o = ctl_reg[CC_SAT_B_BIT];
  assign data_write_saturate_o = ctl_reg[CC_SAT_DW_BIT];
  // one: super saturation with guard bits; zero: 1.31
  assign saturation_point_select_o = ctl_reg[CC_SATPT_BIT];
  assign program_space_window_o = ctl_reg[CC_WINDOW_BIT];
  // one: biased conventional; zero: unbiased convergent
  assign rounding_mode_o = ctl_reg[CC_ROUND_BIT];
  assign integer_mode_o = ctl_reg[CC_INT_BIT];
  assign cpu_priority_level_o = {ctl_reg[CC_PRIO_BIT], cpu_status_reg_i};

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_top_bits_zero: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[15:13] == 3'h0)
    else $error("unused top bits read nonzero");

  chk_umul_follows: assert property (
    wr_hi |=> unsigned_multiply_o == $past(wd[CC_UMUL_BIT]))
    else $error("unsigned multiply not written");

  chk_exit_cause: assert property (
    loop_exit_o |-> $past(loop_iter_end_i) && $past(lp.depth) != 3'h0)
    else $error("loop exit without iteration end");

  chk_exit_reads_zero: assert property (
    s_axi_rvalid_o |-> !s_axi_rdata_o[CC_EXIT_BIT])
    else $error("early exit bit read as one");

  chk_depth_up: assert property (
    loop_start_i && !loop_done_i && !loop_iter_end_i && lp.depth != 3'h7
    |=> lp.depth == $past(lp.depth) + 3'h1)
    else $error("nesting depth did not count up");

  chk_sat_ab: assert property (
    wr_lo |=> accum_a_saturate_o == $past(wd[7]) && accum_b_saturate_o == $past(wd[6]))
    else $error("accumulator saturation not written");

  chk_dw_sat: assert property (
    wr_lo |=> data_write_saturate_o == $past(wd[5]))
    else $error("data write saturation not written");

  chk_sat_point: assert property (
    wr_lo |=> saturation_point_select_o == $past(wd[4]))
    else $error("saturation point not written");

  chk_prio_set: assert property (
    priority_raise_i |=> cpu_priority_level_o[3])
    else $error("priority msb not set");

  chk_prio_no_set: assert property (
    !cpu_priority_level_o[3] && !priority_raise_i |=> !cpu_priority_level_o[3])
    else $error("software set priority msb");

  chk_low_modes: assert property (
    wr_lo |=> {program_space_window_o, rounding_mode_o, integer_mode_o}
      == $past(wd[2:0]))
    else $error("window, rounding or integer mode not written");

  chk_window_mode: assert property (
    wr_lo |=> program_space_window_o == $past(wd[CC_WINDOW_BIT]))
    else $error("program space window not written");

  chk_round_mode: assert property (
    wr_lo |=> rounding_mode_o == $past(wd[CC_ROUND_BIT]))
    else $error("rounding mode not written");

  chk_int_mode: assert property (
    wr_lo |=> integer_mode_o == $past(wd[CC_INT_BIT]))
    else $error("integer mode not written");

  // -------------------------------------------------------------------
  // checks: bits hold between writes
  // -------------------------------------------------------------------
  chk_umul_holds: assert property (
    !wr_hi |=> $stable(unsigned_multiply_o))
    else $error("unsigned multiply changed without a write");

  chk_low_holds: assert property (
    !wr_lo |=> $stable({accum_a_saturate_o, accum_b_saturate_o, data_write_saturate_o,
      saturation_point_select_o, program_space_window_o, rounding_mode_o, integer_mode_o}))
    else $error("mode bit changed without a write");

  // -------------------------------------------------------------------
  // checks: loop counter
  // -------------------------------------------------------------------
  chk_depth_down: assert property (
    loop_done_i && !loop_start_i && lp.depth != 3'h0
    |=> lp.depth == $past(lp.depth) - 3'h1)
    else $error("nesting depth did not count down");

  chk_depth_still: assert property (
    !loop_start_i && !loop_done_i && !loop_iter_end_i |=> $stable(lp.depth))
    else $error("nesting depth moved with no loop event");

  chk_depth_read: assert property (
    $rose(s_axi_rvalid_o) && s_axi_rresp_o == CC_RESP_OKAY
    |-> s_axi_rdata_o[CC_DEPTH_LSB +: CC_DEPTH_W] == $past(lp.depth))
    else $error("nesting depth read back wrong");

  chk_exit_drops: assert property (
    loop_exit_o && !$past(loop_start_i) |-> lp.depth == $past(lp.depth) - 3'h1)
    else $error("early exit did not end a loop");

  // -------------------------------------------------------------------
  // checks: priority msb and reset
  // -------------------------------------------------------------------
  chk_prio_drop: assert property (
    priority_drop_i && !priority_raise_i |=> !cpu_priority_level_o[3])
    else $error("priority msb not dropped");

  chk_prio_clear: assert property (
    wr_lo && !wd[CC_PRIO_BIT] && !priority_raise_i |=> !cpu_priority_level_o[3])
    else $error("software clear of priority msb lost");

  chk_prio_holds: assert property (
    !priority_raise_i && !priority_drop_i && !wr_lo |=> $stable(cpu_priority_level_o[3]))
    else $error("priority msb changed with no cause");

  chk_prio_readback: assert property (
    $rose(s_axi_rvalid_o) && s_axi_rresp_o == CC_RESP_OKAY
    |-> s_axi_rdata_o[CC_PRIO_BIT] == $past(cpu_priority_level_o[3]))
    else $error("priority msb read back wrong");

  // two edges into reset, so the very first edge of the run is not judged
  chk_reset_value: assert property (
    disable iff (1'b0) !rst_n_i ##1 !rst_n_i |-> ctl_reg == CC_RESET && lp.depth == 3'h0)
    else $error("register not at its reset value");

  cov_write: cover property (wr_lo && wr_hi);
  cov_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
  cov_exit: cover property (loop_exit_o);
  cov_prio: cover property (priority_raise_i ##1 wr_lo);
endmodule
`default_nettype wire

// ### core/cc_ifs.sv
/*
 Interfaces between the register bank and its helpers.
 Assumes one clock; all members change after the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
interface cc_reg_if;
  import cc_pkg::*;
  logic wr_req;
  logic [CC_ADDR_W-1:0] wr_addr;
  logic [CC_DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic rd_req;
  logic [CC_ADDR_W-1:0] rd_addr;
  logic [CC_DATA_W-1:0] rd_data;
  logic rd_ok;
  modport slave(output wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr,
                input wr_ok, rd_data, rd_ok);
  modport regs(input wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr,
               output wr_ok, rd_data, rd_ok);
endinterface

interface cc_loop_if #(parameter int unsigned DEPTH_W = 3);
  logic start;
  logic iter_end;
  logic done;
  logic exit_req;
  logic [DEPTH_W-1:0] depth;
  logic exit_now;
  modport track(input start, iter_end, done, exit_req, output depth, exit_now);
  modport ctrl(output start, iter_end, done, exit_req, input depth, exit_now);
endinterface
`default_nettype wire

// ### core/cc_loop_tracker.sv
/*
 Hardware loop nesting counter with early exit.
 Assumes start, iteration-end and done pulses from the loop sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module cc_loop_tracker #(
  parameter int unsigned DEPTH_W = 3
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  cc_loop_if.track lp
);
  localparam logic [DEPTH_W-1:0] MAX_DEPTH = '1;
  logic [DEPTH_W-1:0] depth_reg, depth_next;
  logic pend_reg, pend_next, exit_reg, exit_next;
  logic up, down, cut;

  // refused at elaboration: the nesting field is at most eight bits
  if (DEPTH_W < 1 || DEPTH_W > 8) begin : g_bad_depth_w
    $error("cc_loop_tracker: DEPTH_W out of range");
  end

  always_comb begin
    // early exit ends the innermost loop when its iteration closes
    cut = (pend_reg || lp.exit_req) && lp.iter_end && (depth_reg != '0);
    down = (cut || lp.done) && (depth_reg != '0);
    up = lp.start && (depth_reg != MAX_DEPTH);
    depth_next = depth_reg;
    if (up && !down) begin
      depth_next = depth_reg + 1'b1;
    end else if (down && !up) begin
      depth_next = depth_reg - 1'b1;
    end
    exit_next = cut;
    // request with no loop running has nothing to end
    pend_next = (pend_reg || lp.exit_req) && !cut && (depth_reg != '0);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      depth_reg <= '0;
      pend_reg <= 1'b0;
      exit_reg <= 1'b0;
    end else begin
      depth_reg <= depth_next;
      pend_reg <= pend_next;
      exit_reg <= exit_next;
    end
  end

  assign lp.depth = depth_reg;
  assign lp.exit_now = exit_reg;
endmodule
`default_nettype wire

// ### core/cc_pkg.sv
/*
 Constants for the core control register block: offsets, bit positions,
 reset value and bus answers. Assumes a 32-bit AXI4-Lite register bus.
*/
package cc_pkg;
  localparam int unsigned CC_ADDR_W = 12;
  localparam int unsigned CC_DATA_W = 32;
  localparam int unsigned CC_REG_W = 16;
  localparam logic [CC_ADDR_W-1:0] CC_CORE_CONTROL_OFS = 12'h000;
  localparam int unsigned CC_UMUL_BIT = 12;
  localparam int unsigned CC_EXIT_BIT = 11;
  localparam int unsigned CC_DEPTH_LSB = 8;
  localparam int unsigned CC_SAT_A_BIT = 7;
  localparam int unsigned CC_SAT_B_BIT = 6;
  localparam int unsigned CC_SAT_DW_BIT = 5;
  localparam int unsigned CC_SATPT_BIT = 4;
  localparam int unsigned CC_PRIO_BIT = 3;
  localparam int unsigned CC_WINDOW_BIT = 2;
  localparam int unsigned CC_ROUND_BIT = 1;
  localparam int unsigned CC_INT_BIT = 0;
  localparam logic [15:0] CC_RESET = 16'h0020;
  localparam logic [15:0] CC_WMASK = 16'h10f7;
  localparam int unsigned CC_DEPTH_W = 3;
  localparam logic [1:0] CC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CC_RESP_SLVERR = 2'h2;
  typedef enum logic {CC_RD_IDLE, CC_RD_RESP} cc_rd_e;
endpackage

// ### verification/dsp_core_control_register_bench.sv
/*
 Self-checking bench for the core control register block.
 Assumes the block answers AXI4-Lite requests and takes loop and priority events on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module dsp_core_control_register_bench;
  import cc_pkg::*;

  logic clk_i, rst_n_i;
  logic [11:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [2:0] status;
  logic [4:0] ev;
  logic umul, intm, sat_a, sat_b, sat_dw, sat_pt, pwin, rmode, lexit;
  logic [3:0] prio;
  logic [2:0] depth;
  int bad_count, tests_run, cycles;
  int bits[8] = '{12, 0, 7, 6, 5, 4, 2, 1};

  cc_core_control dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .cpu_status_reg_i(status),
    .priority_raise_i(ev[1]), .priority_drop_i(ev[0]), .loop_start_i(ev[4]),
    .loop_iter_end_i(ev[3]), .loop_done_i(ev[2]), .unsigned_multiply_o(umul),
    .integer_mode_o(intm), .accum_a_saturate_o(sat_a), .accum_b_saturate_o(sat_b),
    .data_write_saturate_o(sat_dw), .saturation_point_select_o(sat_pt),
    .program_space_window_o(pwin), .rounding_mode_o(rmode), .cpu_priority_level_o(prio),
    .loop_nesting_depth_o(depth), .loop_exit_o(lexit)
  );

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      bad_count = bad_count + 1;
    end
  endtask

  // handshakes are sampled at the falling edge, so no race with the design's flops
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw_done, w_done, aw_hit, w_hit, b_hit;
    logic [1:0] resp;
    aw_done = 1'b0;
    w_done = 1'b0;
    b_hit = 1'b0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge clk_i);
      aw_hit = !aw_done && (awready === 1'b1);
      w_hit = !w_done && (wready === 1'b1);
      @(posedge clk_i);
      if (aw_hit) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_hit) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    while (!b_hit) begin
      @(negedge clk_i);
      b_hit = (bvalid === 1'b1);
      resp = bresp;
      @(posedge clk_i);
    end
    bready <= 1'b0;
    cmp("bresp", {30'h0, er}, {30'h0, resp});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ar_hit, r_hit;
    ar_hit = 1'b0;
    r_hit = 1'b0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ar_hit) begin
      @(negedge clk_i);
      ar_hit = (arready === 1'b1);
      @(posedge clk_i);
    end
    arvalid <= 1'b0;
    while (!r_hit) begin
      @(negedge clk_i);
      r_hit = (rvalid === 1'b1);
      if (r_hit) begin
        cmp("rdata", exp, rdata);
        cmp("rresp", {30'h0, er}, {30'h0, rresp});
      end
      @(posedge clk_i);
    end
    rready <= 1'b0;
  endtask

  // one-cycle event: {start, iter_end, done, raise, drop}
  task automatic side(input logic [4:0] v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= 5'h00;
    @(negedge clk_i);
  endtask

  task automatic test_end(input string name);
    $display("test %s done, %0d checks, %0d bad", name, tests_run, bad_count);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    status = 3'h0;
    ev = 5'h00;
    bad_count = 0;
    tests_run = 0;
    cycles = 0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;

    rd(CC_CORE_CONTROL_OFS, 32'h0020, CC_RESP_OKAY);
    cmp("flags", 32'h08, {umul, intm, sat_a, sat_b, sat_dw, sat_pt, pwin, rmode});
    test_end("reset");

    wr(CC_CORE_CONTROL_OFS, 32'hffff_ffff, 4'hf, CC_RESP_OKAY);
    rd(CC_CORE_CONTROL_OFS, 32'h10f7, CC_RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      wr(CC_CORE_CONTROL_OFS, 32'h1 << bits[i], 4'h3, CC_RESP_OKAY);
      rd(CC_CORE_CONTROL_OFS, 32'h1 << bits[i], CC_RESP_OKAY);
      cmp("flags", 32'h80 >> i, {umul, intm, sat_a, sat_b, sat_dw, sat_pt, pwin, rmode});
    end
    wr(CC_CORE_CONTROL_OFS, 32'hffff, 4'h1, CC_RESP_OKAY);
    rd(CC_CORE_CONTROL_OFS, 32'h00f7, CC_RESP_OKAY);
    wr(12'h004, 32'h0, 4'h3, CC_RESP_SLVERR);
    rd(12'h004, 32'h0, CC_RESP_SLVERR);
    rd(CC_CORE_CONTROL_OFS, 32'h00f7, CC_RESP_OKAY);
    wr(CC_CORE_CONTROL_OFS, 32'h0, 4'h3, CC_RESP_OKAY);
    test_end("fields");

    side(5'h10);
    side(5'h08);
    cmp("exit", 32'h0, {31'h0, lexit});
    cmp("depth", 32'h1, {29'h0, depth});
    repeat (7) side(5'h10);
    rd(CC_CORE_CONTROL_OFS, 32'h0700, CC_RESP_OKAY);
    wr(CC_CORE_CONTROL_OFS, 32'h0800, 4'h2, CC_RESP_OKAY);
    rd(CC_CORE_CONTROL_OFS, 32'h0700, CC_RESP_OKAY);
    side(5'h08);
    cmp("exit", 32'h1, {31'h0, lexit});
    cmp("depth", 32'h6, {29'h0, depth});
    side(5'h08);
    cmp("exit", 32'h0, {31'h0, lexit});
    side(5'h04);
    cmp("depth", 32'h5, {29'h0, depth});
    test_end("loops");

    @(posedge clk_i);
    status <= 3'h5;
    side(5'h02);
    cmp("prio", 32'hd, {28'h0, prio});
    rd(CC_CORE_CONTROL_OFS, 32'h0508, CC_RESP_OKAY);
    wr(CC_CORE_CONTROL_OFS, 32'h0008, 4'h1, CC_RESP_OKAY);
    rd(CC_CORE_CONTROL_OFS, 32'h0508, CC_RESP_OKAY);
    wr(CC_CORE_CONTROL_OFS, 32'h0000, 4'h1, CC_RESP_OKAY);
    rd(CC_CORE_CONTROL_OFS, 32'h0500, CC_RESP_OKAY);
    cmp("prio", 32'h5, {28'h0, prio});
    side(5'h02);
    side(5'h01);
    cmp("prio", 32'h5, {28'h0, prio});
    // raise and drop in one cycle: the raise wins
    side(5'h03);
    cmp("prio", 32'hd, {28'h0, prio});
    test_end("priority");

    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(CC_CORE_CONTROL_OFS, 32'h0020, CC_RESP_OKAY);
    test_end("second reset");
    summarize();
  end
endmodule
`default_nettype wire
